//--- verilog/pss_selector.sv
`timescale 1ns/100ps
`include "pss_consts.svh"
// Electronic replacement for a rotary selector with pre-selection
module pss_selector #(
	parameter logic [2:0] TOP_POS = `PSS_TOP_DEFAULT,
	parameter int TIMEOUT_TICKS = 5000,
	parameter int ALARM_TICKS = `PSS_ALARM_TICKS
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic tick,
	input wire logic cycleTick,
	input wire logic [1:0] bootPolicy,
	input wire logic stepAckPolicy,
	input wire logic word_confirm_policy,
	input wire logic eventsEnable,
	input wire logic stepIn,
	input wire logic stepAck,
	input wire logic word_bit0,
	input wire logic word_bit1,
	input wire logic word_bit2,
	input wire logic word_confirm_input,
	input wire logic [2:0] storedPos,
	output logic [2:0] storeData,
	output logic storeWrite,
	output logic [7:1] posOneHot,
	output logic [2:0] posCode,
	output logic [2:0] pendingPos,
	output logic pendingFlag,
	output logic rangeAlarm,
	output logic step_alarm,
	output logic wordAlarm,
	output logic boot_alarm,
	output logic eventPosChange,
	output logic eventStepAlarm,
	output logic eventWordAlarm
);
	// Valid position test, shared by word, boot and restore paths
	function automatic logic pss_in_range(input logic [2:0] p);
		pss_in_range = (p != `PSS_POS_REST) && (p <= TOP_POS);
	endfunction : pss_in_range

	logic [2:0] word;
	logic [2:0] rise;
	logic wordChanged;
	logic stepRise;
	logic stepAckRise;
	logic wordAckRise;
	pss_pkg::pss_state_t state;
	pss_pkg::pss_state_t next_state;
	logic [2:0] next_posCode;
	logic [2:0] next_pendingPos;
	logic next_pendingFlag;
	logic [15:0] timer;
	logic [15:0] next_timer;
	logic [1:0] bootCount;
	logic [1:0] next_bootCount;
	logic next_boot_alarm;
	logic next_storeWrite;
	logic [7:1] next_posOneHot;
	logic next_eventPosChange;
	logic next_eventStepAlarm;
	logic next_eventWordAlarm;
	logic trigRange;
	logic trigStep;
	logic trigWord;
	logic applyReq;
	logic [2:0] applyPos;

	assign word = {word_bit2, word_bit1, word_bit0}; // R11

	////////////////////////////////////////////////////////////////
	// Input edges: step, step ack, word ack, plus word activity
	pss_edge_detect #(
		.WIDTH(3)
	) u_edges (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.din({word_confirm_input, stepAck, stepIn}),
		.rise(rise),
		.changed()
	);

	pss_edge_detect #(
		.WIDTH(3)
	) u_word_edges (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.din(word),
		.rise(),
		.changed(wordChanged)
	);

	assign stepRise = rise[0];
	assign stepAckRise = rise[1];
	assign wordAckRise = rise[2];

	////////////////////////////////////////////////////////////////
	// Alarm stretchers, one each for the range, step and word alarms
	pss_alarm_timer #(
		.TICKS(ALARM_TICKS)
	) u_range_alarm (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.tick(tick),
		.trigger(trigRange),
		.alarm(rangeAlarm)
	);

	pss_alarm_timer #(
		.TICKS(ALARM_TICKS)
	) u_step_alarm (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.tick(tick),
		.trigger(trigStep),
		.alarm(step_alarm)
	);

	pss_alarm_timer #(
		.TICKS(ALARM_TICKS)
	) u_word_alarm (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.tick(tick),
		.trigger(trigWord),
		.alarm(wordAlarm)
	);

	////////////////////////////////////////////////////////////////
	// Sequencer: boot, idle, and one active pre-selection source
	always_comb begin
		next_state = state;
		next_pendingPos = pendingPos;
		next_pendingFlag = pendingFlag;
		next_timer = timer;
		next_bootCount = bootCount;
		next_boot_alarm = boot_alarm;
		trigRange = 1'b0;
		trigStep = 1'b0;
		trigWord = 1'b0;
		applyReq = 1'b0;
		applyPos = posCode;
		// Timer counts down on the tick; zero means expired
		if (tick && timer != 16'h0000) begin
			next_timer = timer - 16'h0001;
		end
		case (state)
			pss_pkg::PSS_ST_BOOT: begin
				if (bootPolicy == pss_pkg::PSS_BOOT_RESTORE) begin
					applyReq = 1'b1;
					next_state = pss_pkg::PSS_ST_IDLE;
					if (pss_in_range(storedPos)) begin // R16
						applyPos = storedPos;
					end else begin
						applyPos = `PSS_POS_REST; // R16
						next_boot_alarm = 1'b1;
					end
				end else begin
					// Hold rest with alarm while cycles elapse
					applyPos = `PSS_POS_REST; // R17
					next_boot_alarm = 1'b1;
					if (cycleTick) begin
						next_bootCount = bootCount + 2'h1;
					end
					if (bootCount == 2'(`PSS_BOOT_CYCLES)) begin
						applyReq = 1'b1;
						next_state = pss_pkg::PSS_ST_IDLE;
						if (pss_in_range(word)) begin // R17
							applyPos = word;
							next_boot_alarm = 1'b0;
						end else if (bootPolicy == pss_pkg::PSS_BOOT_SYNC_RESTORE
							&& pss_in_range(storedPos)) begin
							applyPos = storedPos; // R19
							next_boot_alarm = 1'b0;
						end else begin
							applyPos = `PSS_POS_REST; // R18
						end
					end
				end
			end
			pss_pkg::PSS_ST_IDLE: begin
				if (stepRise) begin
					// Step starts from the applied position
					next_pendingPos = (posCode >= TOP_POS) ? `PSS_POS_FIRST : posCode + 3'h1; // R6
					next_pendingFlag = 1'b1; // R8
					next_timer = 16'(TIMEOUT_TICKS); // R8
					next_state = pss_pkg::PSS_ST_STEP;
				end else if (wordChanged && word != `PSS_POS_REST) begin // R11
					if (pss_in_range(word)) begin // R1
						next_pendingPos = word;
						next_pendingFlag = 1'b1;
						next_timer = 16'(TIMEOUT_TICKS);
						next_state = pss_pkg::PSS_ST_WORD;
					end else begin
						trigRange = 1'b1; // R2
					end
				end
			end
			pss_pkg::PSS_ST_STEP: begin
				// Word input is ignored here
				if (stepRise) begin // R14
					next_pendingPos = (pendingPos >= TOP_POS) ? `PSS_POS_FIRST : pendingPos + 3'h1; // R6
					next_timer = 16'(TIMEOUT_TICKS); // R5
				end else if (stepAckPolicy && stepAckRise) begin // R10
					applyReq = 1'b1;
					applyPos = pendingPos;
					next_pendingFlag = 1'b0;
					next_state = pss_pkg::PSS_ST_IDLE;
				end else if (next_timer == 16'h0000) begin
					next_pendingFlag = 1'b0;
					next_state = pss_pkg::PSS_ST_IDLE;
					if (!stepAckPolicy) begin
						applyReq = 1'b1; // R3
						applyPos = pendingPos;
					end else begin
						trigStep = 1'b1; // R4 R9
					end
				end
			end
			default: begin
				// Word sequence; step input is ignored
				if (wordChanged) begin // R14
					next_timer = 16'(TIMEOUT_TICKS); // R5
					if (pss_in_range(word)) begin // R1
						next_pendingPos = word;
					end else if (word != `PSS_POS_REST) begin
						trigRange = 1'b1; // R2
					end
				end else if (word_confirm_policy && wordAckRise) begin // R13
					applyReq = 1'b1;
					applyPos = pendingPos;
					next_pendingFlag = 1'b0;
					next_state = pss_pkg::PSS_ST_IDLE;
				end else if (next_timer == 16'h0000) begin
					next_pendingFlag = 1'b0;
					next_state = pss_pkg::PSS_ST_IDLE;
					if (!word_confirm_policy) begin
						applyReq = 1'b1; // R12
						applyPos = pendingPos;
					end else begin
						trigWord = 1'b1; // R15
					end
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Applied position, its outputs, storage write and events
	always_comb begin
		next_posCode = posCode;
		next_storeWrite = 1'b0;
		next_eventPosChange = 1'b0;
		if (applyReq || state == pss_pkg::PSS_ST_BOOT) begin
			next_posCode = applyPos;
		end
		if (applyReq && state != pss_pkg::PSS_ST_BOOT) begin
			next_storeWrite = 1'b1; // R21
		end
		if (applyReq && applyPos != posCode) begin
			next_eventPosChange = eventsEnable; // R20
		end
		next_eventStepAlarm = eventsEnable && trigStep; // R20
		next_eventWordAlarm = eventsEnable && trigWord; // R20
		next_posOneHot = '0;
		for (int i = 1; i <= 7; i++) begin
			next_posOneHot[i] = (next_posCode == 3'(i)); // R22
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state <= pss_pkg::PSS_ST_BOOT;
			posCode <= `PSS_POS_REST;
			pendingPos <= `PSS_POS_REST;
			pendingFlag <= 1'b0;
			timer <= 16'h0000;
			bootCount <= 2'h0;
			boot_alarm <= 1'b0;
			storeData <= `PSS_POS_REST;
			storeWrite <= 1'b0;
			posOneHot <= '0;
			eventPosChange <= 1'b0;
			eventStepAlarm <= 1'b0;
			eventWordAlarm <= 1'b0;
		end else begin
			state <= next_state;
			posCode <= next_posCode; // R22
			pendingPos <= next_pendingPos;
			pendingFlag <= next_pendingFlag;
			timer <= next_timer;
			bootCount <= next_bootCount;
			boot_alarm <= next_boot_alarm;
			storeData <= next_posCode; // R21
			storeWrite <= next_storeWrite;
			posOneHot <= next_posOneHot;
			eventPosChange <= next_eventPosChange;
			eventStepAlarm <= next_eventStepAlarm;
			eventWordAlarm <= next_eventWordAlarm;
		end
	end
endmodule : pss_selector

//--- verilog/pss_consts.svh
// Functional notes
// R1 - Apply word only within 1 to top
// R2 - Word above top: range alarm 3 s
// R3 - Step timeout policy applies after inactivity
// R4 - Missed acknowledge discards, keeps position, alarms
// R5 - Any control activity restarts timeout timer
// R6 - Step rising edge advances, wraps to 1
// R7 - Step pulses spaced at least 50 ms; the selector does not check the gap
// R8 - Step edge restarts timer, flags pending position
// R9 - Unacknowledged step raises step alarm 3 s
// R10 - Step acknowledge edge applies, acknowledge policy only
// R11 - Word decodes 1 to 7; zero ignored
// R12 - Word timeout policy applies after last change
// R13 - Word acknowledge edge within timeout applies
// R14 - Step and word sequences lock each other out
// R15 - Unacknowledged word rejected, word alarm 3 s
// R16 - Restore loads stored; bad gives 0, alarm
// R17 - Synchronize holds 0 two cycles, adopts word
// R18 - Failed sync sets 0, boot alarm stays
// R19 - Synch-restore falls back to stored position
// R20 - Events for changes and unconfirmed pre-selections
// R21 - Applied position kept in non-volatile store; applies made during boot raise no store write
// R22 - Tick counts time; one-hot and encoded outputs
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH
`define PSS_ALARM_MS 3000
`define PSS_STEP_GAP_MS 50
`define PSS_TICK_MS 1
`define PSS_ALARM_TICKS (`PSS_ALARM_MS / `PSS_TICK_MS)
`define PSS_BOOT_CYCLES 2
`define PSS_POS_REST 3'h0
`define PSS_POS_FIRST 3'h1
`define PSS_TOP_DEFAULT 3'h7
`endif

//--- verilog/pss_pkg.sv
package pss_pkg;
	typedef enum logic [1:0] {
		PSS_BOOT_RESTORE = 2'b00,
		PSS_BOOT_SYNC = 2'b01,
		PSS_BOOT_SYNC_RESTORE = 2'b10
	} pss_boot_t;
	typedef enum logic [2:0] {
		PSS_ST_BOOT = 3'b000,
		PSS_ST_IDLE = 3'b001,
		PSS_ST_STEP = 3'b010,
		PSS_ST_WORD = 3'b011
	} pss_state_t;
endpackage : pss_pkg

//--- verilog/pss_alarm_timer.sv
`timescale 1ns/100ps
`include "pss_consts.svh"
// Holds an alarm level for a fixed number of ticks after a trigger
module pss_alarm_timer #(
	parameter int TICKS = `PSS_ALARM_TICKS
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic tick,
	input wire logic trigger,
	output logic alarm
);
	logic [15:0] count;
	logic [15:0] next_count;
	logic next_alarm;

	////////////////////////////////////////////////////////////////
	// Retrigger restarts the full period
	always_comb begin
		next_count = count;
		next_alarm = alarm;
		if (trigger) begin
			next_count = 16'(TICKS);
			next_alarm = 1'b1;
		end else if (tick && count != 16'h0000) begin
			next_count = count - 16'h0001;
			next_alarm = (count != 16'h0001);
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			count <= 16'h0000;
			alarm <= 1'b0;
		end else begin
			count <= next_count;
			alarm <= next_alarm;
		end
	end
endmodule : pss_alarm_timer

//--- verilog/pss_edge_detect.sv
`timescale 1ns/100ps
// Combinational rising edge and change detector for a group of inputs, against a registered last sample
module pss_edge_detect #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] rise,
	output logic changed
);
	logic [WIDTH-1:0] last;
	logic [WIDTH-1:0] next_last;

	////////////////////////////////////////////////////////////////
	// Edges are taken combinationally from the previous sample
	always_comb begin
		next_last = din;
		rise = din & ~last;
		changed = (din != last);
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			last <= '0;
		end else begin
			last <= next_last;
		end
	end
endmodule : pss_edge_detect

//--- tb/pss_assertions.sv
`timescale 1ns/100ps
// Output-side checks of the selector
module pss_assertions #(
	parameter logic [2:0] TOP_POS = 3'h7
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [7:1] posOneHot,
	input wire logic [2:0] posCode,
	input wire logic [2:0] storeData,
	input wire logic storeWrite,
	input wire logic eventsEnable,
	input wire logic eventPosChange,
	input wire logic rangeAlarm,
	input wire logic step_alarm,
	input wire logic wordAlarm,
	input wire logic eventStepAlarm,
	input wire logic eventWordAlarm
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////
	// Position 0 shows no one-hot bit at all
	property p_hot; {posOneHot, posCode == 3'h0} == (8'h1 << posCode); endproperty
	a_hot: assert property (p_hot) else $error("one-hot and code disagree");
	property p_top; posCode <= TOP_POS; endproperty
	a_top: assert property (p_top) else $error("position above top");
	// Only real applies are written, never the rest position
	property p_store; storeWrite |-> storeData == posCode && posCode != 3'h0; endproperty
	a_store: assert property (p_store) else $error("stored value not applied one");
	// Refusals leave the position alone
	property p_range; $rose(rangeAlarm) |-> $stable(posCode) ##1 rangeAlarm [*8]; endproperty
	a_range: assert property (p_range) else $error("range alarm wrong");
	property p_step; $rose(step_alarm) |-> $stable(posCode) ##1 step_alarm [*8]; endproperty
	a_step: assert property (p_step) else $error("step alarm wrong");
	property p_word; $rose(wordAlarm) |-> $stable(posCode) ##1 wordAlarm [*8]; endproperty
	a_word: assert property (p_word) else $error("word alarm wrong");
	property p_evs; eventStepAlarm |-> step_alarm; endproperty
	a_evs: assert property (p_evs) else $error("step event without alarm");
	property p_evw; eventWordAlarm |-> wordAlarm; endproperty
	a_evw: assert property (p_evw) else $error("word event without alarm");
	// Every change of position is logged exactly when logging was on
	property p_evp; $changed(posCode) |-> eventPosChange == $past(eventsEnable); endproperty
	a_evp: assert property (p_evp) else $error("position event wrong");
endmodule : pss_assertions

//--- tb/pss_partner.sv
`timescale 1ns/100ps
// Buttons and contacts in front of the selector
module pss_partner #(
	parameter int GAP = 8
) (
	input wire logic core_clk,
	input wire logic [2:0] press,
	input wire logic [2:0] wordReq,
	output logic stepIn,
	output logic stepAck,
	output logic ackWord,
	output logic [2:0] word
);
	int gap = 0;
	initial {stepIn, stepAck, ackWord, word} = 6'h0;
	// A step press inside the gap is swallowed, like a debounced button
	always @(posedge core_clk) begin
		stepIn <= press[0] && gap == 0;
		gap <= stepIn ? GAP : (gap > 0 ? gap - 1 : 0);
		stepAck <= press[1];
		ackWord <= press[2];
		word <= wordReq;
	end
endmodule : pss_partner

//--- tb/testbench.sv
`timescale 1ns/100ps
module testbench;
	localparam logic [2:0] TOP = 3'h5;
	localparam int SETTLE = (5 + 4 + 3) * 16;
	logic core_clk = 0, sys_rst = 1, tick = 0, cycleTick = 0, stepAckPolicy = 0, wcPolicy = 0;
	logic [1:0] bootPolicy = 2'h0;
	logic [2:0] press = 3'h0, wordReq = 3'h0, storedPos = 3'h3, word, posCode, pendingPos, storeData, st;
	logic [7:1] posOneHot;
	logic stepIn, stepAck, ackWord, storeWrite, rangeAlarm, step_alarm, wordAlarm, boot_alarm;
	logic evStep, evWord, evPos, pendFlag, evEn = 1, sawRange = 0, sawStep = 0, sawWord = 0;
	logic sawEvStep = 0, sawEvWord = 0;
	logic [3:0] cnt = 4'h0;
	logic [31:0] seed = 32'h6fdb;
	logic [2:0] expPos [$];
	int failures = 0, checked = 0;
	pss_partner pss_partner_i (.core_clk(core_clk), .press(press), .wordReq(wordReq), .stepIn(stepIn),
		.stepAck(stepAck), .ackWord(ackWord), .word(word));
	pss_selector #(.TOP_POS(TOP), .TIMEOUT_TICKS(5), .ALARM_TICKS(4)) pss_selector_i (.core_clk(core_clk),
		.sys_rst(sys_rst), .tick(tick), .cycleTick(cycleTick), .bootPolicy(bootPolicy),
		.stepAckPolicy(stepAckPolicy), .word_confirm_policy(wcPolicy), .eventsEnable(evEn),
		.stepIn(stepIn), .stepAck(stepAck), .word_bit0(word[0]), .word_bit1(word[1]), .word_bit2(word[2]),
		.word_confirm_input(ackWord), .storedPos(storedPos), .storeData(storeData), .storeWrite(storeWrite),
		.posOneHot(posOneHot), .posCode(posCode), .pendingPos(pendingPos), .pendingFlag(pendFlag),
		.rangeAlarm(rangeAlarm), .step_alarm(step_alarm), .wordAlarm(wordAlarm), .boot_alarm(boot_alarm),
		.eventPosChange(evPos), .eventStepAlarm(evStep), .eventWordAlarm(evWord));
	////////////////////////////////////////
	always #25 core_clk = ~core_clk;
	// Time base scaled down: one tick per 16 clocks keeps the run short
	always @(posedge core_clk) begin
		cnt <= cnt + 4'h1;
		tick <= cnt == 4'h0;
		cycleTick <= cnt[2:0] == 3'h0;
	end
	// Wide enough for a flag or two in front of a position
	task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// Applies are matched in order against the noted positions
	always @(negedge core_clk) begin
		if (storeWrite === 1'b1) chk("apply", 8'(posCode), 8'(expPos.size() > 0 ? expPos.pop_front() : 3'hx));
		if (storeWrite === 1'b1) chk("apply event", {7'h0, evPos}, {7'h0, evEn});
		if (rangeAlarm === 1'b1) sawRange = 1;
		if (step_alarm === 1'b1) sawStep = 1;
		if (wordAlarm === 1'b1) sawWord = 1;
		if (evStep === 1'b1) sawEvStep = 1;
		if (evWord === 1'b1) sawEvWord = 1;
	end
	function automatic logic [31:0] xs(logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs
	task automatic boot(logic [1:0] p, logic [2:0] s, logic [2:0] w);
		@(posedge core_clk) {sys_rst, bootPolicy, storedPos, wordReq} <= {1'b1, p, s, w};
		repeat (16) @(posedge core_clk);
		sys_rst <= 0;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
	endtask : boot
	task automatic hit(logic [2:0] m);
		@(posedge core_clk) press <= m;
		@(posedge core_clk) press <= 3'h0;
	endtask : hit
	// Fixed wait covers timeout plus a whole alarm, so scenarios never overlap
	task automatic settle;
		repeat (SETTLE) @(posedge core_clk);
		@(negedge core_clk);
	endtask : settle
	task automatic stop_test;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	////////////////////////////////////////
	initial begin
		seed = xs(seed);
		st = 3'(seed % 32'(TOP)) + 3'h1;
		boot(2'h0, st, 3'h0);
		chk("restore", 8'(posCode), 8'(st));
		boot(2'h0, 3'h6, 3'h0);
		chk("bad store", 8'({boot_alarm, posCode}), 8'h8);
		boot(2'h0, TOP, 3'h0);
		hit(3'h1);
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		chk("pending", 8'({pendFlag, pendingPos}), 8'h9);
		expPos.push_back(3'h1);
		settle();
		$display("step timeout done");
		@(posedge core_clk) stepAckPolicy <= 1;
		hit(3'h1);
		settle();
		chk("step alarm", 8'({sawEvStep, sawStep, posCode}), 8'h19);
		expPos.push_back(3'h2);
		hit(3'h1);
		repeat (20) @(posedge core_clk);
		hit(3'h2);
		settle();
		@(posedge core_clk) stepAckPolicy <= 0;
		hit(3'h2);
		settle();
		chk("ack ignored", 8'({pendFlag, posCode}), 8'h2);
		$display("step ack done");
		expPos.push_back(3'h3);
		wordReq <= 3'h3;
		settle();
		wordReq <= 3'h6;
		settle();
		chk("range", 8'({sawRange, posCode}), 8'hb);
		wordReq <= 3'h0;
		settle();
		chk("rest", 8'(posCode), 8'h3);
		// Logging off for one apply: no position event may follow
		@(posedge core_clk) evEn <= 1'b0;
		expPos.push_back(3'h4);
		hit(3'h1);
		repeat (4) @(posedge core_clk);
		wordReq <= 3'h1;
		settle();
		$display("word timeout done");
		@(posedge core_clk) {wcPolicy, evEn} <= 2'b11;
		wordReq <= 3'h2;
		settle();
		chk("word alarm", 8'({sawEvWord, sawWord, posCode}), 8'h1c);
		chk("word alarm seen", {7'h0, sawWord}, 8'h1);
		expPos.push_back(3'h5);
		wordReq <= 3'h5;
		repeat (20) @(posedge core_clk);
		hit(3'h4);
		settle();
		$display("word ack done");
		boot(2'h1, 3'h3, 3'h2);
		chk("sync hold", 8'({boot_alarm, posCode}), 8'h8);
		settle();
		chk("sync", 8'({boot_alarm, posCode}), 8'h2);
		boot(2'h1, 3'h3, 3'h0);
		settle();
		chk("sync fail", 8'({boot_alarm, posCode}), 8'h8);
		boot(2'h2, 3'h3, 3'h7);
		settle();
		chk("sync restore", 8'({boot_alarm, posCode}), 8'h3);
		chk("queue", 8'(expPos.size()), 8'h0);
		$display("boot done");
		stop_test();
	end
	// Watchdog sized well beyond the whole sequence
	initial begin
		#(8000 * 50);
		failures++;
		stop_test();
	end
endmodule : testbench
bind pss_selector pss_assertions #(.TOP_POS(TOP_POS)) pss_assertions_i (.core_clk(core_clk),
	.sys_rst(sys_rst), .posOneHot(posOneHot), .posCode(posCode), .storeData(storeData),
	.storeWrite(storeWrite), .eventsEnable(eventsEnable), .eventPosChange(eventPosChange),
	.rangeAlarm(rangeAlarm), .step_alarm(step_alarm), .wordAlarm(wordAlarm),
	.eventStepAlarm(eventStepAlarm), .eventWordAlarm(eventWordAlarm));
